// ===== verilog/kwdru_pkg.sv
// constants and types shared by the keyed watchdog reset unit
package kwdru_pkg;

  // core clock
  localparam int unsigned CORE_PERIOD_NS = 40;

  // register byte offsets
  localparam logic [4:0] OFF_WDOG_CONTROL = 5'h00;
  localparam logic [4:0] OFF_RESET_CAUSE  = 5'h04;
  localparam logic [4:0] OFF_IRQ_STATUS   = 5'h08;
  localparam logic [4:0] OFF_IRQ_MASK     = 5'h0c;
  localparam logic [4:0] OFF_CPU_STATUS   = 5'h10;
  localparam logic [4:0] OFF_PORT_INIT    = 5'h14;

  // wdog_control fields
  localparam int unsigned KEY_LSB = 3;
  localparam int unsigned KEY_W   = 5;
  localparam int unsigned SEL_LSB = 0;
  localparam int unsigned SEL_W   = 3;
  localparam logic [4:0]  KEY_DISABLE = 5'h15;
  localparam logic [4:0]  KEY_ENABLE  = 5'h0a;
  localparam logic [7:0]  WDOG_CONTROL_RST = 8'h53;

  // reset_cause_flags and status fields
  localparam int unsigned CAUSE_KEY_BIT  = 0;
  localparam int unsigned STAT_TO_BIT    = 0;
  localparam int unsigned STAT_PWRDN_BIT = 1;
  localparam int unsigned STAT_RUN_BIT   = 2;

  // interrupt events
  localparam int unsigned IRQ_W          = 3;
  localparam int unsigned IRQ_KEY_FAULT  = 0;
  localparam int unsigned IRQ_TIMEOUT    = 1;
  localparam int unsigned IRQ_SLEEP_TO   = 2;
  localparam logic [2:0]  IRQ_MASK_RST   = 3'h0;

  // port init register: data in low byte, direction in high byte
  localparam logic [15:0] PORT_INIT_RST = 16'hffff;

  // counter
  localparam int unsigned CNT_W = 18;
  localparam logic [4:0] PERIOD_EXP [8] = '{
    5'd8, 5'd10, 5'd12, 5'd14, 5'd15, 5'd16, 5'd17, 5'd18
  };

  // delays
  localparam int unsigned SOFT_FAULT_DELAY_NS = 400;
  localparam int unsigned SOFT_FAULT_DELAY_CYC =
    (SOFT_FAULT_DELAY_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int unsigned STARTUP_DELAY_NS = 2000;
  localparam int unsigned STARTUP_DELAY_CYC =
    (STARTUP_DELAY_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int unsigned DLY_W = 8;

  typedef enum logic [1:0] {
    KWDRU_FLT_IDLE  = 2'b00,
    KWDRU_FLT_DELAY = 2'b01,
    KWDRU_FLT_FIRE  = 2'b11
  } kwdru_flt_t;

endpackage

// ===== verilog/kwdru_cnt_if.sv
// carrier between the watchdog control logic and its counter
interface kwdru_cnt_if;
  logic       tick;
  logic       clr;
  logic       en;
  logic [2:0] sel;
  logic       ovf;

  modport ctl (output tick, output clr, output en, output sel, input ovf);
  modport cnt (input tick, input clr, input en, input sel, output ovf);
endinterface

// ===== verilog/kwdru_sync.sv
// two-flop synchroniser for pin-level inputs
module kwdru_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  // data
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } kwdru_sync_st_t;

  kwdru_sync_st_t s_q;
  kwdru_sync_st_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.meta = async_i;
    s_d.stab = s_q.meta;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_o = s_q.stab;

endmodule

// ===== verilog/kwdru_counter.sv
// watchdog up-counter advanced by slow oscillator ticks
module kwdru_counter (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  // control side
  kwdru_cnt_if.cnt  cif
);

  typedef struct packed {
    logic [kwdru_pkg::CNT_W-1:0] cnt;
    logic                        ovf;
  } kwdru_cnt_st_t;

  kwdru_cnt_st_t               s_q;
  kwdru_cnt_st_t               s_d;
  logic [kwdru_pkg::CNT_W-1:0] limit;

  always_comb begin
    limit = kwdru_pkg::CNT_W'((19'd1 << kwdru_pkg::PERIOD_EXP[cif.sel])
                              - 19'd1);
    s_d     = s_q;
    s_d.ovf = 1'b0;
    if (cif.tick) begin
      if (cif.clr) begin
        s_d.cnt = '0;
      end else if (cif.en) begin
        if (s_q.cnt == limit) begin
          s_d.cnt = '0;
          s_d.ovf = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cif.ovf = s_q.ovf;

endmodule

// ===== verilog/kwdru_top.sv
// keyed watchdog reset unit: registers, key check, flags, reset outputs
// Behaviour
// - counter advances only on slow oscillator edges
// - period select picks 2^8 .. 2^18 ticks
// - key 10101 stops, 01010 runs watchdog
// - any other key: device reset after delay
// - key cause flag set; cleared by zero write
// - control resets to key 01010, period 011
// - normal overflow resets device, sets timeout
// - sleep overflow: timeout, power-down, PC/SP reset
// - invalid key write also clears counter
// - clear instruction clears counter without halting
// - halt instruction clears the counter
// - reset pin low clears counter if selected
// - cause register upper four bits read zero
// - start-up delay, then run from address zero
// - port data and direction start all ones
// - counter runs in sleep; halt clears it
// - power-down flag: clear instr clears, halt sets
module kwdru_top (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // slow oscillator and reset pin
  input  wire logic        slow_internal_osc_i,
  input  wire logic        ext_init_pin_n_i,
  input  wire logic        pin_guard_is_reset_i,
  // cpu events
  input  wire logic        watchdog_clear_instruction_i,
  input  wire logic        halt_i,
  input  wire logic        sleep_mode_i,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // reset and status outputs
  output logic             device_reset_o,
  output logic             warm_reset_o,
  output logic             cpu_run_o,
  output logic             timeout_flag_o,
  output logic             power_down_flag_o,
  output logic [7:0]       port_data_o,
  output logic [7:0]       port_dir_o,
  output logic             irq_o
);

  typedef struct packed {
    logic [7:0]                      ctrl;
    logic [7:0]                      ctrl_slow;
    logic                            key_cause;
    logic                            to;
    logic                            pwr_dn;
    logic                            clr_pend;
    logic                            osc_prev;
    logic                            tick;
    kwdru_pkg::kwdru_flt_t           flt;
    logic [kwdru_pkg::DLY_W-1:0]     dly;
    logic [kwdru_pkg::DLY_W-1:0]     start_cnt;
    logic                            run;
    logic [kwdru_pkg::IRQ_W-1:0]     irq_st;
    logic [kwdru_pkg::IRQ_W-1:0]     irq_mask;
    logic                            irq;
    logic                            dev_rst;
    logic                            warm_rst;
    logic [15:0]                     port_init;
    logic                            wait_n;
    logic [31:0]                     rdata;
  } kwdru_st_t;

  kwdru_st_t  s_q;
  kwdru_st_t  s_d;
  logic [1:0] pins_s;
  logic       osc_s;
  logic       pin_low_s;

  kwdru_cnt_if cif ();

  // pin inverted so the synchroniser's reset value is its idle level
  kwdru_sync #(
    .W (2)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .async_i    ({slow_internal_osc_i, !ext_init_pin_n_i}),
    .sync_o     (pins_s)
  );

  kwdru_counter u_counter (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .cif        (cif)
  );

  assign osc_s     = pins_s[1];
  assign pin_low_s = pins_s[0];

  // counter control
  assign cif.tick = s_q.tick;
  assign cif.clr  = s_q.clr_pend;
  assign cif.en   = s_q.ctrl_slow[kwdru_pkg::KEY_LSB +: kwdru_pkg::KEY_W]
                    == kwdru_pkg::KEY_ENABLE;
  assign cif.sel  = s_q.ctrl_slow[kwdru_pkg::SEL_LSB +:
                                  kwdru_pkg::SEL_W];

  always_comb begin
    logic [4:0]                  key;
    logic                        key_bad;
    logic                        acc;
    logic                        do_wr;
    logic                        do_rd;
    logic [2:0]                  widx;
    logic                        clr_req;
    logic [kwdru_pkg::IRQ_W-1:0] ev;
    key     = s_q.ctrl[kwdru_pkg::KEY_LSB +: kwdru_pkg::KEY_W];
    key_bad = (key != kwdru_pkg::KEY_ENABLE)
              && (key != kwdru_pkg::KEY_DISABLE);
    acc     = (avs_read_i || avs_write_i) && s_q.wait_n == 1'b0;
    do_wr   = avs_write_i && s_q.wait_n;
    do_rd   = avs_read_i && s_q.wait_n;
    widx    = avs_address_i[4:2];
    clr_req = 1'b0;
    ev      = '0;
    s_d     = s_q;

    s_d.dev_rst  = 1'b0;
    s_d.warm_rst = 1'b0;

    // slow oscillator edge; prev resets to the idle low level
    s_d.osc_prev = osc_s;
    s_d.tick     = osc_s && !s_q.osc_prev;

    // start-up delay
    if (!s_q.run) begin
      if (s_q.start_cnt == kwdru_pkg::DLY_W'(
            kwdru_pkg::STARTUP_DELAY_CYC - 1)) begin
        s_d.run = 1'b1;
      end else begin
        s_d.start_cnt = s_q.start_cnt + 1'b1;
      end
    end

    // one wait cycle per access
    s_d.wait_n = acc;

    // register reads
    if (acc && avs_read_i) begin
      s_d.rdata = '0;
      case (widx)
        kwdru_pkg::OFF_WDOG_CONTROL[4:2]: begin
          s_d.rdata[7:0] = s_q.ctrl;
        end
        kwdru_pkg::OFF_RESET_CAUSE[4:2]: begin
          // other reset causes live elsewhere and read zero here
          s_d.rdata[7:1] = 7'h00;
          s_d.rdata[kwdru_pkg::CAUSE_KEY_BIT] = s_q.key_cause;
        end
        kwdru_pkg::OFF_IRQ_STATUS[4:2]: begin
          s_d.rdata[kwdru_pkg::IRQ_W-1:0] = s_q.irq_st;
        end
        kwdru_pkg::OFF_IRQ_MASK[4:2]: begin
          s_d.rdata[kwdru_pkg::IRQ_W-1:0] = s_q.irq_mask;
        end
        kwdru_pkg::OFF_CPU_STATUS[4:2]: begin
          s_d.rdata[kwdru_pkg::STAT_TO_BIT]  = s_q.to;
          s_d.rdata[kwdru_pkg::STAT_PWRDN_BIT] = s_q.pwr_dn;
          s_d.rdata[kwdru_pkg::STAT_RUN_BIT] = s_q.run;
        end
        kwdru_pkg::OFF_PORT_INIT[4:2]: begin
          s_d.rdata[15:0] = s_q.port_init;
        end
        default: begin
          s_d.rdata = '0;
        end
      endcase
    end

    // the answered read clears only the bits it returned, so an
    // event caught while the read was pending is kept
    if (do_rd && widx == kwdru_pkg::OFF_IRQ_STATUS[4:2]) begin
      s_d.irq_st = s_q.irq_st & ~s_q.rdata[kwdru_pkg::IRQ_W-1:0];
    end

    // register writes
    if (do_wr) begin
      case (widx)
        kwdru_pkg::OFF_WDOG_CONTROL[4:2]: begin
          s_d.ctrl = avs_writedata_i[7:0];
        end
        kwdru_pkg::OFF_RESET_CAUSE[4:2]: begin
          if (!avs_writedata_i[kwdru_pkg::CAUSE_KEY_BIT]) begin
            s_d.key_cause = 1'b0;
          end
        end
        kwdru_pkg::OFF_IRQ_MASK[4:2]: begin
          s_d.irq_mask = avs_writedata_i[kwdru_pkg::IRQ_W-1:0];
        end
        kwdru_pkg::OFF_PORT_INIT[4:2]: begin
          s_d.port_init = avs_writedata_i[15:0];
        end
        default: begin
          s_d.irq_mask = s_q.irq_mask;
        end
      endcase
    end

    // clear sources
    if (watchdog_clear_instruction_i) begin
      clr_req    = 1'b1;
      s_d.pwr_dn = 1'b0;
    end
    // halt and clear in one cycle leave power-down set
    if (halt_i) begin
      clr_req    = 1'b1;
      s_d.pwr_dn = 1'b1;
      s_d.to     = 1'b0;
    end
    if (pin_low_s && pin_guard_is_reset_i) begin
      clr_req = 1'b1;
    end
    if (key_bad) begin
      clr_req = 1'b1;
    end

    // pending clear held until the next slow tick
    if (s_q.tick) begin
      s_d.clr_pend = 1'b0;
    end
    if (clr_req) begin
      s_d.clr_pend = 1'b1;
    end

    // control reaches the counter only at a slow tick, so a write
    // never changes period or enable halfway through a tick
    if (s_q.tick) begin
      s_d.ctrl_slow = s_q.ctrl;
    end

    // overflow handling
    if (cif.ovf) begin
      s_d.to = 1'b1;
      if (sleep_mode_i) begin
        s_d.pwr_dn   = 1'b1;
        s_d.warm_rst = 1'b1;
        ev[kwdru_pkg::IRQ_SLEEP_TO] = 1'b1;
      end else begin
        s_d.dev_rst = 1'b1;
        ev[kwdru_pkg::IRQ_TIMEOUT] = 1'b1;
      end
    end

    // invalid key sequencer
    case (s_q.flt)
      kwdru_pkg::KWDRU_FLT_IDLE: begin
        if (key_bad) begin
          s_d.flt = kwdru_pkg::KWDRU_FLT_DELAY;
          s_d.dly = '0;
        end
      end
      kwdru_pkg::KWDRU_FLT_DELAY: begin
        if (s_q.dly == kwdru_pkg::DLY_W'(
              kwdru_pkg::SOFT_FAULT_DELAY_CYC - 1)) begin
          s_d.flt = kwdru_pkg::KWDRU_FLT_FIRE;
        end else begin
          s_d.dly = s_q.dly + 1'b1;
        end
      end
      kwdru_pkg::KWDRU_FLT_FIRE: begin
        s_d.dev_rst   = 1'b1;
        s_d.key_cause = 1'b1;
        // restored key is valid, so one fault fires only once
        s_d.ctrl      = kwdru_pkg::WDOG_CONTROL_RST;
        ev[kwdru_pkg::IRQ_KEY_FAULT] = 1'b1;
        s_d.flt       = kwdru_pkg::KWDRU_FLT_IDLE;
      end
      default: begin
        s_d.flt = kwdru_pkg::KWDRU_FLT_IDLE;
      end
    endcase

    // events win over a clearing read
    s_d.irq_st = s_d.irq_st | ev;
    s_d.irq    = |(s_d.irq_st & s_d.irq_mask);
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s_q.ctrl      <= kwdru_pkg::WDOG_CONTROL_RST;
      s_q.ctrl_slow <= kwdru_pkg::WDOG_CONTROL_RST;
      s_q.key_cause <= 1'b0;
      s_q.to        <= 1'b0;
      s_q.pwr_dn    <= 1'b0;
      s_q.clr_pend  <= 1'b0;
      s_q.osc_prev  <= 1'b0;
      s_q.tick      <= 1'b0;
      s_q.flt       <= kwdru_pkg::KWDRU_FLT_IDLE;
      s_q.dly       <= '0;
      s_q.start_cnt <= '0;
      s_q.run       <= 1'b0;
      s_q.irq_st    <= '0;
      s_q.irq_mask  <= kwdru_pkg::IRQ_MASK_RST;
      s_q.irq       <= 1'b0;
      s_q.dev_rst   <= 1'b0;
      s_q.warm_rst  <= 1'b0;
      s_q.port_init <= kwdru_pkg::PORT_INIT_RST;
      s_q.wait_n    <= 1'b0;
      s_q.rdata     <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata_o    = s_q.rdata;
  assign avs_waitrequest_o = !s_q.wait_n;
  assign device_reset_o    = s_q.dev_rst;
  assign warm_reset_o      = s_q.warm_rst;
  assign cpu_run_o         = s_q.run;
  assign timeout_flag_o    = s_q.to;
  assign power_down_flag_o = s_q.pwr_dn;
  assign port_data_o       = s_q.port_init[7:0];
  assign port_dir_o        = s_q.port_init[15:8];
  assign irq_o             = s_q.irq;

endmodule

// ===== dv/kwdru_top_assertions.sv
// port-level assertions for the keyed watchdog reset unit
module kwdru_top_assertions (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // cpu events and register bus
  input  wire logic        watchdog_clear_instruction_i,
  input  wire logic        halt_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [31:0] avs_readdata_o,
  input  wire logic        avs_waitrequest_o,
  // reset and status outputs
  input  wire logic        device_reset_o,
  input  wire logic        warm_reset_o,
  input  wire logic        cpu_run_o,
  input  wire logic        timeout_flag_o,
  input  wire logic        power_down_flag_o,
  input  wire logic [7:0]  port_data_o,
  input  wire logic [7:0]  port_dir_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  logic       ack_w;
  logic [4:0] key_w;
  assign ack_w = avs_write_i && !avs_waitrequest_o;
  assign key_w = avs_writedata_i[7:3];

  property p_key_fault;
    ack_w && avs_address_i == kwdru_pkg::OFF_WDOG_CONTROL &&
      key_w != kwdru_pkg::KEY_ENABLE && key_w != kwdru_pkg::KEY_DISABLE
      |-> ##[8:20] device_reset_o;
  endproperty
  a_key_fault: assert property (p_key_fault)
    else $error("no device reset after bad key");

  property p_dev_pulse;
    device_reset_o |=> !device_reset_o && !warm_reset_o;
  endproperty
  a_dev_pulse: assert property (p_dev_pulse)
    else $error("device reset longer than one cycle");

  property p_to_cause;
    $rose(timeout_flag_o) |-> (device_reset_o || warm_reset_o ||
      $past(device_reset_o) || $past(warm_reset_o)) or
      ##1 (device_reset_o || warm_reset_o);
  endproperty
  a_to_cause: assert property (p_to_cause)
    else $error("timeout flag without overflow");

  property p_warm;
    warm_reset_o |-> ##[0:1] (timeout_flag_o && power_down_flag_o);
  endproperty
  a_warm: assert property (p_warm)
    else $error("sleep overflow flags wrong");

  property p_halt;
    halt_i |-> ##[1:3] (power_down_flag_o && !timeout_flag_o);
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt flags wrong");

  property p_clr;
    watchdog_clear_instruction_i |-> ##[1:3] !power_down_flag_o;
  endproperty
  a_clr: assert property (p_clr)
    else $error("clear did not drop power-down flag");

  property p_cause_hi;
    avs_read_i && !avs_waitrequest_o &&
      avs_address_i == kwdru_pkg::OFF_RESET_CAUSE
      |-> avs_readdata_o[31:1] == 31'h0;
  endproperty
  a_cause_hi: assert property (p_cause_hi)
    else $error("cause upper bits not zero");

  property p_port;
    $rose(rst_n_i) |-> port_data_o == 8'hff && port_dir_o == 8'hff;
  endproperty
  a_port: assert property (p_port)
    else $error("port init not all ones");

  property p_start;
    $rose(rst_n_i) |-> ##45 !cpu_run_o ##[1:12] cpu_run_o;
  endproperty
  a_start: assert property (p_start)
    else $error("start-up delay wrong");
endmodule

bind kwdru_top kwdru_top_assertions i_chk (
  .core_clk_i, .rst_n_i, .watchdog_clear_instruction_i, .halt_i,
  .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
  .avs_waitrequest_o, .device_reset_o, .warm_reset_o, .cpu_run_o,
  .timeout_flag_o, .power_down_flag_o, .port_data_o, .port_dir_o
);

// ===== dv/test_keyed_watchdog_reset_unit.sv
// self-checking bench for the keyed watchdog reset unit
module test_keyed_watchdog_reset_unit;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk, rst_n, osc, pin_n, guard, clr, halt, slp, rd, wr;
  logic        wait_r, dev_rst, warm_rst, run, to_f, pd_f, irq;
  logic [4:0]  adr, k;
  logic [7:0]  pdat, pdir;
  logic [31:0] wdat, rdat;
  logic [31:0] exp_q[$];
  int          fails = 0, checks = 0, dev_cnt = 0, warm_cnt = 0, n0;

  kwdru_top i_dut (
    .core_clk_i          (clk),
    .rst_n_i             (rst_n),
    .slow_internal_osc_i (osc),
    .ext_init_pin_n_i    (pin_n),
    .pin_guard_is_reset_i(guard),
    .watchdog_clear_instruction_i (clr),
    .halt_i              (halt),
    .sleep_mode_i        (slp),
    .avs_address_i       (adr),
    .avs_read_i          (rd),
    .avs_write_i         (wr),
    .avs_writedata_i     (wdat),
    .avs_readdata_o      (rdat),
    .avs_waitrequest_o   (wait_r),
    .device_reset_o      (dev_rst),
    .warm_reset_o        (warm_rst),
    .cpu_run_o           (run),
    .timeout_flag_o      (to_f),
    .power_down_flag_o   (pd_f),
    .port_data_o         (pdat),
    .port_dir_o          (pdir),
    .irq_o               (irq)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wait_r !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdx(input logic [4:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  // slow oscillator: one tick every four core cycles
  task automatic ticks(input int n);
    repeat (n) begin
      osc <= 1'b1;
      repeat (2) @(posedge clk);
      osc <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask

  // 0 halt, 1 and 3 reset pin, else clear instruction
  task automatic clear_by(input int m);
    case (m)
      0: halt <= 1'b1;
      1, 3: pin_n <= 1'b0;
      default: clr <= 1'b1;
    endcase
    @(posedge clk);
    halt <= 1'b0;
    clr <= 1'b0;
    ticks(1);
    pin_n <= 1'b1;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (dev_rst === 1'b1) dev_cnt++;
    if (warm_rst === 1'b1) warm_cnt++;
    if (rd && wait_r === 1'b0 && exp_q.size() > 0)
      chk(rdat, exp_q.pop_front());
  end

  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    final_report;
  end

  initial begin
    {rst_n, osc, clr, halt, slp, rd, wr} = '0;
    {pin_n, guard} = 2'b11;
    adr = '0;
    wdat = '0;
    void'($urandom(32'h4362ac09));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(32'({pdir, pdat}), 32'hffff);
    rdx(5'h00, 32'h53);
    rdx(5'h04, 32'h0);
    rdx(5'h14, 32'hffff);
    rdx(5'h18, 32'h0);
    repeat (60) @(posedge clk);
    rdx(5'h10, 32'h4);
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, 5'h00, {24'($urandom), 5'h0a, 3'(s)});
      rdx(5'h00, {24'h0, 5'h0a, 3'(s)});
      clear_by(2);
      n0 = dev_cnt;
      ticks((1 << (8 + 2 * s)) - 8);
      chk(dev_cnt, n0);
      ticks(16);
      chk(dev_cnt, n0 + 1);
      chk(32'(to_f), 32'h1);
    end
    chk(32'(irq), 32'h0);
    rdx(5'h08, 32'h2);
    rdx(5'h08, 32'h0);
    bus(1'b1, 5'h00, 32'h50);
    ticks(100);
    n0 = dev_cnt;
    for (int m = 0; m < 4; m++) begin
      guard <= (m != 3);
      clear_by(m);
      if (m == 0) chk(32'({to_f, pd_f}), 32'h1);
      if (m == 2) chk(32'(pd_f), 32'h0);
      ticks(200);
      chk(dev_cnt, n0 + (m == 3));
    end
    clear_by(0);
    slp <= 1'b1;
    ticks(264);
    slp <= 1'b0;
    chk(warm_cnt, 1);
    chk(dev_cnt, n0 + 1);
    chk(32'({to_f, pd_f}), 32'h3);
    bus(1'b1, 5'h00, 32'ha8);
    clear_by(2);
    ticks(300);
    chk(dev_cnt + warm_cnt, n0 + 2);
    bus(1'b1, 5'h0c, 32'h7);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    rdx(5'h08, 32'h6);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    bus(1'b1, 5'h00, 32'h50);
    ticks(200);
    do k = 5'($urandom); while (k == 5'h0a || k == 5'h15);
    n0 = dev_cnt;
    bus(1'b1, 5'h00, {24'h0, k, 3'h2});
    repeat (30) @(posedge clk);
    chk(dev_cnt, n0 + 1);
    rdx(5'h00, 32'h53);
    rdx(5'h04, 32'h1);
    rdx(5'h08, 32'h1);
    bus(1'b1, 5'h04, 32'h1);
    rdx(5'h04, 32'h1);
    bus(1'b1, 5'h04, 32'hfffffffe);
    rdx(5'h04, 32'h0);
    bus(1'b1, 5'h00, 32'h50);
    ticks(100);
    chk(dev_cnt, n0 + 1);
    final_report;
  end
endmodule
